// File: acr_pkg.sv
// constants and types of the accelerometer configuration register slice
package acr_pkg;
   localparam logic [7:0] ADDR_Z_THR_HIGH = 8'h36;
   localparam logic [7:0] ADDR_Z_THR_LOW  = 8'h37;
   localparam logic [7:0] ADDR_HPF        = 8'h38;
   localparam logic [7:0] ADDR_PIN_A_MAP  = 8'h3b;
   localparam logic [7:0] ADDR_PIN_B_MAP  = 8'h3c;
   localparam logic [7:0] ADDR_TIMING     = 8'h3d;

   // writable bits of each register
   localparam logic [7:0] MASK_Z_THR_HIGH = 8'hff;
   localparam logic [7:0] MASK_Z_THR_LOW  = 8'he1;
   localparam logic [7:0] MASK_HPF        = 8'h03;
   localparam logic [7:0] MASK_PIN_MAP    = 8'hf1;
   localparam logic [7:0] MASK_TIMING     = 8'hff;
   localparam logic [7:0] RESET_VALUE     = 8'h00;

   localparam int POS_AXIS_EN     = 0;
   localparam int POS_ACTIVE_LOW  = 7;
   localparam int POS_AWAKE       = 6;
   localparam int POS_ACTIVITY    = 5;
   localparam int POS_INACTIVITY  = 4;
   localparam int POS_SAMPLE_RDY  = 0;
   localparam int POS_EXT_CLOCK   = 1;
   localparam int POS_EXT_TRIGGER = 0;

   localparam logic [2:0] RATE_CODE_MAX = 3'h4;

   // timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int FAST_RATE_HZ = 5120;
   localparam int WAKE_UNIT_MS = 5;
   localparam int FAST_RATE_CYCLES = CLK_HZ / FAST_RATE_HZ;
   localparam int WAKE_UNIT_CYCLES = CLK_HZ / 1000 * WAKE_UNIT_MS;

   // wake periods 65..30720 ms as multiples of the 5 ms unit
   localparam logic [12:0] WAKE_MULT [8] = '{
      13'h000d, 13'h001a, 13'h0034, 13'h0080,
      13'h0200, 13'h0400, 13'h0800, 13'h1800};

   // corner in hundredths of Hz at the fastest output rate
   localparam logic [11:0] CORNER_CHZ [4] = '{
      12'hbe8, 12'h616, 12'h314, 12'h18c};

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acr_req_t;

   typedef struct packed {
      logic       awake;
      logic       activity;
      logic       inactivity;
      logic       sample_ready;
   } acr_events_t;

   typedef struct packed {
      logic [2:0] output_rate_select;
      logic [2:0] wake_timer_period;
      logic       external_clock_enable;
      logic       external_trigger_enable;
   } acr_timing_t;
endpackage

// File: acr_tick_div.sv
// divider giving a one-cycle tick every period cycles
`timescale 1ns/100ps
module acr_tick_div #(
   parameter int W = 32
) (
   input  wire logic         clk,     // system clock
   input  wire logic         sys_rst, // synchronous reset
   input  wire logic         run,     // count while high
   input  wire logic [W-1:0] period,  // cycles per tick
   output      logic         tick     // one-cycle pulse
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   wire          at_end;

   if (W < 2) begin : g_bad_width
      $error("acr_tick_div width too small");
   end

   // a period cut below the current count restarts the counter at the next clock
   assign at_end     = (count >= period - W'(1));
   assign next_count = at_end ? '0 : count + W'(1);

   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= at_end;
      end
   end
endmodule // acr_tick_div

// File: acr_config_regs.sv
// configuration register slice with interrupt routing and rate timing
`timescale 1ns/100ps
module acr_config_regs #(
   parameter int FAST_RATE_CYCLES = acr_pkg::FAST_RATE_CYCLES,
   parameter int WAKE_UNIT_CYCLES = acr_pkg::WAKE_UNIT_CYCLES
) (
   input  wire logic                clk,              // 100 MHz
   input  wire logic                sys_rst,          // sync reset
   input  wire acr_pkg::acr_req_t   reg_req,          // register access
   output      logic [7:0]          reg_rdata,        // read data
   output      logic                reg_rvalid,       // read data valid
   input  wire acr_pkg::acr_events_t events,          // event conditions
   input  wire logic [11:0]         z_sample,         // z accel, signed
   input  wire logic                z_sample_valid,   // z sample strobe
   input  wire logic                ext_clock_tick,   // external clock
   input  wire logic                ext_trigger,      // external trigger
   output      logic                irq_pin_a_out,    // pin a level
   output      logic                irq_pin_a_oe,     // pin a driven
   output      logic                irq_pin_b_out,    // pin b level
   output      logic                irq_pin_b_oe,     // pin b driven
   output      logic [10:0]         z_motion_warn_threshold, // threshold
   output      logic                z_motion_warn_axis_enable, // z used
   output      logic                z_motion_warn_hit, // z over limit
   output      logic [1:0]          highpass_corner_code, // corner
   output      logic [11:0]         highpass_corner_chz, // corner 0.01Hz
   output      acr_pkg::acr_timing_t timing,          // timing fields
   output      logic                sample_tick,      // sample moment
   output      logic                wake_tick         // wake-up moment
);
   // stored registers
   logic [7:0] z_thr_high;
   logic [7:0] z_thr_low;
   logic [7:0] hpf_reg;
   logic [7:0] pin_a_map;
   logic [7:0] pin_b_map;
   logic [7:0] timing_reg;

   if (FAST_RATE_CYCLES < 2) begin : g_bad_rate
      $error("FAST_RATE_CYCLES must be at least 2");
   end
   if (WAKE_UNIT_CYCLES < 1) begin : g_bad_wake
      $error("WAKE_UNIT_CYCLES must be at least 1");
   end
   if (longint'(WAKE_UNIT_CYCLES) * 6144 > 64'hffff_ffff) begin : g_bad_w
      $error("WAKE_UNIT_CYCLES too large for the wake divider");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] merge_write(
      input logic [7:0] old_value,
      input logic [7:0] new_value,
      input logic [7:0] mask
   );
      merge_write = (old_value & ~mask) | (new_value & mask);
   endfunction

   function automatic logic [2:0] clamp_rate(input logic [2:0] code);
      clamp_rate = (code > acr_pkg::RATE_CODE_MAX) ?
                   acr_pkg::RATE_CODE_MAX : code;
   endfunction

   // events of one routing register OR'ed, reserved bits held zero
   function automatic logic routed_or(
      input logic [7:0]          map,
      input acr_pkg::acr_events_t ev
   );
      routed_or =
         (map[acr_pkg::POS_AWAKE]      & ev.awake)      |
         (map[acr_pkg::POS_ACTIVITY]   & ev.activity)   |
         (map[acr_pkg::POS_INACTIVITY] & ev.inactivity) |
         (map[acr_pkg::POS_SAMPLE_RDY] & ev.sample_ready);
   endfunction

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire hit_thr_high = (reg_req.addr == acr_pkg::ADDR_Z_THR_HIGH);
   wire hit_thr_low  = (reg_req.addr == acr_pkg::ADDR_Z_THR_LOW);
   wire hit_hpf      = (reg_req.addr == acr_pkg::ADDR_HPF);
   wire hit_pin_a    = (reg_req.addr == acr_pkg::ADDR_PIN_A_MAP);
   wire hit_pin_b    = (reg_req.addr == acr_pkg::ADDR_PIN_B_MAP);
   wire hit_timing   = (reg_req.addr == acr_pkg::ADDR_TIMING);

   wire wr_thr_high  = reg_req.wr & hit_thr_high;
   wire wr_thr_low   = reg_req.wr & hit_thr_low;
   wire wr_hpf       = reg_req.wr & hit_hpf;
   wire wr_pin_a     = reg_req.wr & hit_pin_a;
   wire wr_pin_b     = reg_req.wr & hit_pin_b;
   wire wr_timing    = reg_req.wr & hit_timing;

   // reserved bits never take a written one
   wire [7:0] next_thr_high = merge_write(z_thr_high, reg_req.wdata,
                                          acr_pkg::MASK_Z_THR_HIGH);
   wire [7:0] next_thr_low  = merge_write(z_thr_low, reg_req.wdata,
                                          acr_pkg::MASK_Z_THR_LOW);
   wire [7:0] next_hpf      = merge_write(hpf_reg, reg_req.wdata,
                                          acr_pkg::MASK_HPF);
   wire [7:0] next_pin_a    = merge_write(pin_a_map, reg_req.wdata,
                                          acr_pkg::MASK_PIN_MAP);
   wire [7:0] next_pin_b    = merge_write(pin_b_map, reg_req.wdata,
                                          acr_pkg::MASK_PIN_MAP);
   wire [7:0] next_timing   = merge_write(timing_reg, reg_req.wdata,
                                          acr_pkg::MASK_TIMING);

   // read mux; unmapped addresses read zero
   wire [7:0] read_mux =
      hit_thr_high ? z_thr_high :
      hit_thr_low  ? z_thr_low  :
      hit_hpf      ? hpf_reg    :
      hit_pin_a    ? pin_a_map  :
      hit_pin_b    ? pin_b_map  :
      hit_timing   ? timing_reg : 8'h00;

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         z_thr_high <= acr_pkg::RESET_VALUE;
         z_thr_low  <= acr_pkg::RESET_VALUE;
         hpf_reg    <= acr_pkg::RESET_VALUE;
         pin_a_map  <= acr_pkg::RESET_VALUE;
         pin_b_map  <= acr_pkg::RESET_VALUE;
         timing_reg <= acr_pkg::RESET_VALUE;
      end else begin
         if (wr_thr_high) z_thr_high <= next_thr_high;
         if (wr_thr_low)  z_thr_low  <= next_thr_low;
         if (wr_hpf)      hpf_reg    <= next_hpf;
         if (wr_pin_a)    pin_a_map  <= next_pin_a;
         if (wr_pin_b)    pin_b_map  <= next_pin_b;
         if (wr_timing)   timing_reg <= next_timing;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd) reg_rdata <= read_mux;
      end
   end

   // ---------------------------------------------------------------
   // z motion warning threshold and compare
   // ---------------------------------------------------------------
   wire [10:0] z_threshold = {z_thr_high, z_thr_low[7:5]};
   wire        z_enable    = z_thr_low[acr_pkg::POS_AXIS_EN];

   // magnitude of a 12-bit two's complement sample
   wire        z_negative  = z_sample[11];
   wire [11:0] z_magnitude = z_negative ? (~z_sample + 12'h001) : z_sample;
   wire        z_over      = z_magnitude > {1'b0, z_threshold};
   wire        z_hit_now   = z_enable & z_over;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         z_motion_warn_threshold   <= 11'h000;
         z_motion_warn_axis_enable <= 1'b0;
         z_motion_warn_hit         <= 1'b0;
      end else begin
         z_motion_warn_threshold   <= z_threshold;
         z_motion_warn_axis_enable <= z_enable;
         if (!z_enable) begin
            z_motion_warn_hit <= 1'b0;
         end else if (z_sample_valid) begin
            z_motion_warn_hit <= z_hit_now;
         end
      end
   end

   // ---------------------------------------------------------------
   // timing fields
   // ---------------------------------------------------------------
   wire [2:0] rate_code   = timing_reg[7:5];
   wire [2:0] wake_code   = timing_reg[4:2];
   wire       external_clock_enable_en  = timing_reg[acr_pkg::POS_EXT_CLOCK];
   wire       ext_trig_en = timing_reg[acr_pkg::POS_EXT_TRIGGER];
   wire [2:0] rate_used   = clamp_rate(rate_code);

   // period doubles for each step below the fastest rate
   wire [2:0]  rate_shift  = acr_pkg::RATE_CODE_MAX - rate_used;
   wire [31:0] fast_period = 32'(FAST_RATE_CYCLES);
   wire [31:0] rate_period = fast_period << rate_shift;

   wire [31:0] wake_unit   = 32'(WAKE_UNIT_CYCLES);
   wire [31:0] wake_mult   = {19'h00000, acr_pkg::WAKE_MULT[wake_code]};
   wire [31:0] wake_period = 32'(wake_unit * wake_mult);

   // ---------------------------------------------------------------
   // rate dividers
   // ---------------------------------------------------------------
   wire internal_rate_tick;
   wire internal_wake_tick;
   wire rate_div_run = ~external_clock_enable_en & ~ext_trig_en;

   acr_tick_div #(
      .W (32)
   ) u_rate_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (rate_div_run),
      .period  (rate_period),
      .tick    (internal_rate_tick)
   );

   acr_tick_div #(
      .W (32)
   ) u_wake_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (1'b1),
      .period  (wake_period),
      .tick    (internal_wake_tick)
   );

   // trigger overrides external clock, which overrides the divider
   wire sample_src =
      ext_trig_en ? ext_trigger    :
      external_clock_enable_en  ? ext_clock_tick :
      internal_rate_tick;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample_tick <= 1'b0;
         wake_tick   <= 1'b0;
         timing      <= '0;
      end else begin
         sample_tick <= sample_src;
         wake_tick   <= internal_wake_tick;
         timing      <= '{output_rate_select:      rate_code,
                          wake_timer_period:       wake_code,
                          external_clock_enable:   external_clock_enable_en,
                          external_trigger_enable: ext_trig_en};
      end
   end

   // ---------------------------------------------------------------
   // high-pass corner
   // ---------------------------------------------------------------
   wire [1:0]  corner_code = hpf_reg[1:0];
   wire [11:0] corner_fast = acr_pkg::CORNER_CHZ[corner_code];
   wire [11:0] corner_now  = corner_fast >> rate_shift;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         highpass_corner_code <= 2'h0;
         highpass_corner_chz  <= 12'h000;
      end else begin
         highpass_corner_code <= corner_code;
         highpass_corner_chz  <= corner_now;
      end
   end

   // ---------------------------------------------------------------
   // interrupt pins
   // ---------------------------------------------------------------
   wire pin_a_any  = |pin_a_map[6:0];
   wire pin_b_any  = |pin_b_map[6:0];
   wire pin_a_cond = routed_or(pin_a_map, events);
   wire pin_b_cond = routed_or(pin_b_map, events);
   wire pin_a_low  = pin_a_map[acr_pkg::POS_ACTIVE_LOW];
   wire pin_b_low  = pin_b_map[acr_pkg::POS_ACTIVE_LOW];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_pin_a_out <= 1'b0;
         irq_pin_a_oe  <= 1'b0;
         irq_pin_b_out <= 1'b0;
         irq_pin_b_oe  <= 1'b0;
      end else begin
         irq_pin_a_out <= pin_a_cond ^ pin_a_low;
         irq_pin_a_oe  <= pin_a_any;
         irq_pin_b_out <= pin_b_cond ^ pin_b_low;
         irq_pin_b_oe  <= pin_b_any;
      end
   end
endmodule // acr_config_regs

// File: acr_config_regs_sva.sv
// assertion checker for the configuration register slice
`timescale 1ns/100ps
module acr_config_regs_sva #(
   parameter int FAST_RATE_CYCLES = 4,
   parameter int WAKE_UNIT_CYCLES = 2
) (
   input wire logic                 clk,             // clock
   input wire logic                 sys_rst,         // sync reset
   input wire acr_pkg::acr_req_t    reg_req,         // request
   input wire logic [7:0]           reg_rdata,       // read data
   input wire logic                 reg_rvalid,      // read valid
   input wire acr_pkg::acr_events_t events,          // events
   input wire logic [11:0]          z_sample,        // z sample
   input wire logic                 z_sample_valid,  // z strobe
   input wire logic                 ext_trigger,     // trigger
   input wire logic                 irq_pin_a_out,   // pin a
   input wire logic                 irq_pin_a_oe,    // pin a oe
   input wire logic                 irq_pin_b_out,   // pin b
   input wire logic                 irq_pin_b_oe,    // pin b oe
   input wire logic [10:0]          z_motion_warn_threshold,   // limit
   input wire logic                 z_motion_warn_axis_enable, // z on
   input wire logic                 z_motion_warn_hit,         // hit
   input wire logic [1:0]           highpass_corner_code,      // corner
   input wire acr_pkg::acr_timing_t timing,          // timing
   input wire logic                 sample_tick      // sample pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [7:0]  map_a;
   logic [7:0]  map_b;
   logic [11:0] z_abs;
   logic        exp_a;
   logic        exp_b;
   logic        z_exp;
   logic        unmapped;
   wire  [7:0]  ad = reg_req.addr;
   wire  [7:0]  wd = reg_req.wdata;
   // shadow of the routing registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         map_a <= 8'h00;
         map_b <= 8'h00;
      end else begin
         if (reg_req.wr && ad == 8'h3b) map_a <= wd & 8'hf1;
         if (reg_req.wr && ad == 8'h3c) map_b <= wd & 8'hf1;
      end
   end
   assign exp_a = (|({map_a[6:4], map_a[0]} & events)) ^ map_a[7];
   assign exp_b = (|({map_b[6:4], map_b[0]} & events)) ^ map_b[7];
   assign z_abs = z_sample[11] ? 12'h000 - z_sample : z_sample;
   assign z_exp = z_motion_warn_axis_enable &&
                  (z_abs > {1'b0, z_motion_warn_threshold});
   assign unmapped = !(ad inside {8'h36, 8'h37, 8'h38, 8'h3b, 8'h3c,
                                  8'h3d});
   property p_pin_a;
      1 |=> irq_pin_a_oe == $past(|map_a[6:0]) &&
            (!irq_pin_a_oe || irq_pin_a_out == $past(exp_a));
   endproperty
   a_pin_a: assert property (p_pin_a) else $error("pin a wrong");
   property p_pin_b;
      1 |=> irq_pin_b_oe == $past(|map_b[6:0]) &&
            (!irq_pin_b_oe || irq_pin_b_out == $past(exp_b));
   endproperty
   a_pin_b: assert property (p_pin_b) else $error("pin b wrong");
   property p_z_hit;
      z_sample_valid |=> z_motion_warn_hit == $past(z_exp);
   endproperty
   a_z_hit: assert property (p_z_hit) else $error("z hit wrong");
   property p_thr_high;
      reg_req.wr && ad == 8'h36 |->
         ##2 z_motion_warn_threshold[10:3] == $past(wd, 2);
   endproperty
   a_thr_high: assert property (p_thr_high) else $error("thr hi");
   property p_thr_low;
      reg_req.wr && ad == 8'h37 |-> ##2
         {z_motion_warn_threshold[2:0], z_motion_warn_axis_enable} ==
         {$past(wd[7:5], 2), $past(wd[0], 2)};
   endproperty
   a_thr_low: assert property (p_thr_low) else $error("thr lo");
   property p_corner;
      reg_req.wr && ad == 8'h38 |->
         ##2 highpass_corner_code == $past(wd[1:0], 2);
   endproperty
   a_corner: assert property (p_corner) else $error("corner");
   property p_timing;
      reg_req.wr && ad == 8'h3d |-> ##2 timing == $past(wd, 2);
   endproperty
   a_timing: assert property (p_timing) else $error("timing");
   property p_unmapped;
      reg_req.rd && unmapped |=> reg_rvalid && reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmap");
   property p_ext_trig;
      timing.external_trigger_enable && ext_trigger |=> sample_tick;
   endproperty
   a_ext_trig: assert property (p_ext_trig) else $error("trig");
   c_unmapped: cover property (reg_req.rd && unmapped);
   c_pin_a: cover property (irq_pin_a_oe && irq_pin_a_out);
   c_z_hit: cover property (z_motion_warn_hit);
endmodule // acr_config_regs_sva

bind acr_config_regs acr_config_regs_sva #(
   .FAST_RATE_CYCLES(FAST_RATE_CYCLES),
   .WAKE_UNIT_CYCLES(WAKE_UNIT_CYCLES)
) u_sva (
   .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .events(events),
   .z_sample(z_sample), .z_sample_valid(z_sample_valid),
   .ext_trigger(ext_trigger), .irq_pin_a_out(irq_pin_a_out),
   .irq_pin_a_oe(irq_pin_a_oe), .irq_pin_b_out(irq_pin_b_out),
   .irq_pin_b_oe(irq_pin_b_oe),
   .z_motion_warn_threshold(z_motion_warn_threshold),
   .z_motion_warn_axis_enable(z_motion_warn_axis_enable),
   .z_motion_warn_hit(z_motion_warn_hit),
   .highpass_corner_code(highpass_corner_code), .timing(timing),
   .sample_tick(sample_tick)
);

// File: acr_host_model.sv
// host model issuing one register request per clock
`timescale 1ns/100ps
module acr_host_model (
   input  wire logic        clk,     // system clock
   output acr_pkg::acr_req_t reg_req // register request
);
   initial reg_req = '0;
   task automatic op(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
   endtask
   task automatic idle();
      @(posedge clk);
      reg_req <= '0;
   endtask
endmodule // acr_host_model

// File: tb_accel_config_irq_timing_regs.sv
// self-checking bench for the configuration register slice
`timescale 1ns/100ps
module tb_accel_config_irq_timing_regs;
   logic                 clk = 1'b0;
   logic                 sys_rst = 1'b1;
   acr_pkg::acr_req_t    reg_req;
   logic [7:0]           rdata;
   logic                 rvalid;
   acr_pkg::acr_events_t ev = '0;
   logic [11:0]          z_s = '0;
   logic                 z_v = 1'b0;
   logic                 e_clk = 1'b0;
   logic                 e_trg = 1'b0;
   logic                 a_out, a_oe, b_out, b_oe, z_en, z_hit;
   logic                 s_tick, w_tick;
   logic [10:0]          z_thr;
   logic [1:0]           hp_code;
   logic [11:0]          hp_chz;
   acr_pkg::acr_timing_t tim;
   logic [7:0]           exp_q[$];
   int                   mismatches = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;
   logic [7:0] adr[6] = '{8'h36, 8'h37, 8'h38, 8'h3b, 8'h3c, 8'h3d};
   logic [7:0] msk[6] = '{8'hff, 8'he1, 8'h03, 8'hf1, 8'hf1, 8'hff};
   int         wms[8] = '{65, 130, 260, 640, 2560, 5120, 10240, 30720};

   always #5 clk = ~clk;

   acr_host_model host (.clk(clk), .reg_req(reg_req));
   acr_config_regs #(.FAST_RATE_CYCLES(4), .WAKE_UNIT_CYCLES(2)) DUT (
      .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .events(ev),
      .z_sample(z_s), .z_sample_valid(z_v), .ext_clock_tick(e_clk),
      .ext_trigger(e_trg), .irq_pin_a_out(a_out), .irq_pin_a_oe(a_oe),
      .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe),
      .z_motion_warn_threshold(z_thr), .z_motion_warn_axis_enable(z_en),
      .z_motion_warn_hit(z_hit), .highpass_corner_code(hp_code),
      .highpass_corner_chz(hp_chz), .timing(tim), .sample_tick(s_tick),
      .wake_tick(w_tick));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.op(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.op(1'b1, a, d);
   endtask
   task automatic settle(input int n);
      host.idle();
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pins(input logic [7:0] ma, input logic [7:0] mb);
      logic [3:0] e;
      e = 4'($urandom);
      wr(8'h3b, ma);
      wr(8'h3c, mb);
      ev <= e;
      settle(2);
      check(16'(a_oe), 16'(|(ma & 8'h71)));
      check(16'(b_oe), 16'(|(mb & 8'h71)));
      if (|(ma & 8'h71)) check(16'(a_out), 16'((|({ma[6:4], ma[0]} & e)) ^ ma[7]));
      if (|(mb & 8'h71)) check(16'(b_out), 16'((|({mb[6:4], mb[0]} & e)) ^ mb[7]));
   endtask
   task automatic zs(input logic [11:0] s, input logic e);
      @(posedge clk);
      z_s <= s;
      z_v <= 1'b1;
      @(posedge clk);
      z_v <= 1'b0;
      @(posedge clk);
      #1;
      check(16'(z_hit), 16'(e));
   endtask
   task automatic gap(input logic wk, output int n);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while ((wk ? w_tick : s_tick) !== 1'b1 && n < 70000);
      end
   endtask
   task automatic pulse(input logic use_clk);
      @(posedge clk);
      if (use_clk) e_clk <= 1'b1;
      else e_trg <= 1'b1;
      @(posedge clk);
      e_clk <= 1'b0;
      e_trg <= 1'b0;
      #1;
      check(16'(s_tick), 16'h1);
   endtask

   // read results come back in request order
   always @(posedge clk) begin
      if (rvalid === 1'b1) check(16'(rdata), 16'(exp_q.pop_front()));
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      logic [10:0] th;
      int          n;
      void'($urandom(36));
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (adr[i]) rd(adr[i], 8'h00);
      rd(8'h39, 8'h00);
      foreach (adr[i]) wr(adr[i], 8'hff);
      wr(8'h39, 8'hff);
      foreach (adr[i]) rd(adr[i], msk[i]);
      rd(8'h39, 8'h00);
      settle(2);
      for (int i = 0; i < 24; i++) pins(8'($urandom), 8'($urandom));
      th = 11'($urandom);
      wr(8'h36, th[10:3]);
      wr(8'h37, {th[2:0], 5'h1f});
      settle(3);
      check(16'(z_thr), 16'(th));
      check(16'(z_en), 16'h1);
      zs(12'(th) + 12'h001, 1'b1);
      zs(12'(th), 1'b0);
      zs(12'h000 - 12'(th), 1'b0);
      zs(12'h000 - 12'(th) - 12'h001, 1'b1);
      wr(8'h37, 8'h00);
      settle(3);
      check(16'(z_en), 16'h0);
      zs(12'h800, 1'b0);
      for (int c = 0; c < 4; c++) begin
         wr(8'h38, {6'h3f, 2'(c)});
         wr(8'h3d, 8'h80);
         settle(3);
         check(16'(hp_code), 16'(c));
         if (c == 0) check(16'(hp_chz), 16'hbe8);
         if (c == 1) check(16'(hp_chz), 16'h616);
      end
      wr(8'h38, 8'h00);
      wr(8'h3d, 8'h60);
      settle(3);
      check(16'(hp_chz), 16'h5f4);
      for (int r = 0; r < 5; r++) begin
         wr(8'h3d, {3'(r), 5'h00});
         settle(3);
         gap(1'b0, n);
         check(16'(n), 16'(4 << (4 - r)));
      end
      wr(8'h3d, 8'h01);
      settle(3);
      pulse(1'b0);
      wr(8'h3d, 8'h02);
      settle(3);
      pulse(1'b1);
      for (int w = 0; w < 8; w++) begin
         wr(8'h3d, {3'h4, 3'(w), 2'h0});
         settle(3);
         check(16'(tim), {8'h00, 3'h4, 3'(w), 2'h0});
         gap(1'b1, n);
         check(16'(n), 16'(wms[w] / 5 * 2));
      end
      stop_test();
   end
endmodule // tb_accel_config_irq_timing_regs
